// >>> hdl/bmc_pkg.sv
// Constants for the basic mode control register block
package bmc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0] BMC_ADDR_CONTROL = 5'h00;
  localparam logic [15:0] BMC_RESET_VALUE = 16'h1140;
  // Bits that software may change; 11, 6 and 5..0 are read-only
  localparam logic [15:0] BMC_WRITE_MASK = 16'hF780;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BMC_BIT_SOFT_RESET = 15;
  localparam int BMC_BIT_LOOPBACK = 14;
  localparam int BMC_BIT_SPEED_LO = 13;
  localparam int BMC_BIT_NEG_ON = 12;
  localparam int BMC_BIT_LOW_POWER = 11;
  localparam int BMC_BIT_ISOLATE = 10;
  localparam int BMC_BIT_RENEG = 9;
  localparam int BMC_BIT_DUPLEX = 8;
  localparam int BMC_BIT_COL_CHECK = 7;
  localparam int BMC_BIT_SPEED_HI = 6;
  // ----------------------------------------
  // Speed codes
  // ----------------------------------------
  localparam logic [1:0] BMC_SPEED_10 = 2'h0;
  localparam logic [1:0] BMC_SPEED_100 = 2'h1;
  localparam logic [1:0] BMC_SPEED_1000 = 2'h2;
  localparam logic [1:0] BMC_SPEED_RSVD = 2'h3;
  // ----------------------------------------
  // Soft reset timing
  // ----------------------------------------
  localparam int BMC_CLK_PERIOD_NS = 100;
  localparam int BMC_SOFT_RESET_NS = 800;
  localparam logic [3:0] BMC_SOFT_RESET_CYCLES =
    4'((BMC_SOFT_RESET_NS + BMC_CLK_PERIOD_NS - 1) / BMC_CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    BMC_ST_IDLE = 3'h1,
    BMC_ST_RESETTING = 3'h2,
    BMC_ST_DONE = 3'h4
  } bmc_rst_state_t;
endpackage : bmc_pkg

// >>> hdl/bmc_soft_reset.sv
// Sequencer for the self-clearing standard register reset
`timescale 1ns/1ns
module bmc_soft_reset (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic std_reset_o,
  output logic done_o
);
  import bmc_pkg::*;
  bmc_rst_state_t state_reg;
  bmc_rst_state_t state_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic std_reset_reg;
  logic std_reset_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    std_reset_next = 1'b0;
    done_next = 1'b0;
    case (state_reg)
      BMC_ST_IDLE: begin
        if (start_i) begin
          state_next = BMC_ST_RESETTING;
          count_next = BMC_SOFT_RESET_CYCLES;
          std_reset_next = 1'b1;
        end
      end
      BMC_ST_RESETTING: begin
        std_reset_next = 1'b1;
        if (count_reg <= 4'h1) begin
          state_next = BMC_ST_DONE;
          std_reset_next = 1'b0;
          done_next = 1'b1;
        end else begin
          count_next = count_reg - 4'h1;
        end
      end
      BMC_ST_DONE: begin
        state_next = BMC_ST_IDLE;
      end
      default: begin
        state_next = BMC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= BMC_ST_IDLE;
      count_reg <= 4'h0;
      std_reset_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      std_reset_reg <= std_reset_next;
      done_reg <= done_next;
    end
  end

  assign std_reset_o = std_reset_reg;
  assign done_o = done_reg;
endmodule : bmc_soft_reset

// >>> hdl/bmc_basic_mode_control.sv
// Basic mode control register and its control outputs
// How it works
// R1 - Writing bit 15 starts standard register reset; bit clears itself afterwards
// R2 - Bit 14 loops MAC transmit data back to MAC receive
// R3 - Bits 6 and 13 form forced speed code when negotiation off
// R4 - Register resets to 0x1140
// R5 - Bit 12 enables negotiation; off means speed and duplex bits rule
// R6 - Bit 11 shows power-down state, read-only, resets zero
// R7 - Bit 10 isolates MAC-side pins
// R8 - Bit 9 write restarts negotiation, hardware clears it once started
// R9 - Bit 8 selects full or half duplex
// R10 - Bit 7 enables collision signal test
// R11 - Hardware-updated fields may read differently from last write
// R12 - Soft reset touches only standard registers, not vendor ones
// R13 - Software must not modify unlisted register offsets
// R14 - Register at address zero; bits 5..0 read zero, ignore writes
`timescale 1ns/1ns
module bmc_basic_mode_control (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic mgmt_wr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic low_power_state_i,
  input wire logic renegotiate_ack_i,
  output logic [15:0] mgmt_rdata_o,
  output logic std_regs_reset_o,
  output logic loopback_o,
  output logic [1:0] forced_speed_o,
  output logic link_negotiation_on_o,
  output logic isolate_o,
  output logic renegotiate_link_o,
  output logic full_duplex_o,
  output logic collision_signal_check_o
);
  import bmc_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic low_power_reg;
  logic low_power_next;
  logic start_reset;
  logic std_reset;
  logic reset_done;
  logic wr_hit;

  assign wr_hit = mgmt_wr_i && (mgmt_addr_i == BMC_ADDR_CONTROL);
  // R1 start on write
  assign start_reset = wr_hit && mgmt_wdata_i[BMC_BIT_SOFT_RESET];

  bmc_soft_reset u_soft_reset (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(start_reset),
    .std_reset_o(std_reset),
    .done_o(reset_done)
  );

  always_comb begin
    ctrl_next = ctrl_reg;
    // R6 tracks device state
    low_power_next = low_power_state_i;
    if (wr_hit) begin
      // R14 masked write
      ctrl_next = (ctrl_reg & ~BMC_WRITE_MASK) | (mgmt_wdata_i & BMC_WRITE_MASK);
    end
    // R8 hardware clears restart; a new write of one wins
    if (ctrl_reg[BMC_BIT_RENEG] && renegotiate_ack_i &&
        !(wr_hit && mgmt_wdata_i[BMC_BIT_RENEG])) begin
      ctrl_next[BMC_BIT_RENEG] = 1'b0;
    end
    // R1 R12 reinit then self-clear
    if (reset_done) begin
      ctrl_next = BMC_RESET_VALUE;
    end else if (std_reset) begin
      ctrl_next = BMC_RESET_VALUE;
      ctrl_next[BMC_BIT_SOFT_RESET] = 1'b1;
    end
    // R11 R6 read-only fields from hardware
    ctrl_next[BMC_BIT_LOW_POWER] = 1'b0;
    rdata_next = 16'h0000;
    if (mgmt_addr_i == BMC_ADDR_CONTROL) begin
      rdata_next = ctrl_reg;
      rdata_next[BMC_BIT_LOW_POWER] = low_power_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      // R4 reset value
      ctrl_reg <= BMC_RESET_VALUE;
      rdata_reg <= 16'h0000;
      low_power_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      low_power_reg <= low_power_next;
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign mgmt_rdata_o = rdata_reg;
  assign std_regs_reset_o = ctrl_reg[BMC_BIT_SOFT_RESET];
  // R2 loopback
  assign loopback_o = ctrl_reg[BMC_BIT_LOOPBACK];
  // R3 R5 speed code
  assign forced_speed_o = {ctrl_reg[BMC_BIT_SPEED_HI], ctrl_reg[BMC_BIT_SPEED_LO]};
  // R5 negotiation enable
  assign link_negotiation_on_o = ctrl_reg[BMC_BIT_NEG_ON];
  // R7 isolate
  assign isolate_o = ctrl_reg[BMC_BIT_ISOLATE];
  // R8 restart request
  assign renegotiate_link_o = ctrl_reg[BMC_BIT_RENEG];
  // R9 duplex
  assign full_duplex_o = ctrl_reg[BMC_BIT_DUPLEX];
  // R10 collision test
  assign collision_signal_check_o = ctrl_reg[BMC_BIT_COL_CHECK];
endmodule : bmc_basic_mode_control

// >>> test/bmc_checker.sv
// Port assertions for the control register
`timescale 1ns/1ns
module bmc_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic mgmt_wr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic low_power_state_i,
  input wire logic renegotiate_ack_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic std_regs_reset_o,
  input wire logic loopback_o,
  input wire logic [1:0] forced_speed_o,
  input wire logic link_negotiation_on_o,
  input wire logic isolate_o,
  input wire logic renegotiate_link_o,
  input wire logic full_duplex_o,
  input wire logic collision_signal_check_o
);
  wire logic t = mgmt_wr_i && mgmt_addr_i == 5'h00 && !std_regs_reset_o;
  wire logic w = t && !mgmt_wdata_i[15];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_busy;
    std_regs_reset_o [*8];
  endsequence
  a_soft_reset: assert property (
    t && mgmt_wdata_i[15] |=> s_busy ##[1:4] (!std_regs_reset_o && !loopback_o))
    else $error("soft reset");
  a_loop_bit: assert property (
    w |=> loopback_o == $past(mgmt_wdata_i[14])) else $error("loop");
  a_speed_bits: assert property (
    w |=> forced_speed_o == {$past(forced_speed_o[1]), $past(mgmt_wdata_i[13])})
    else $error("speed");
  a_reset_value: assert property (
    $past(rst_i) |-> link_negotiation_on_o && full_duplex_o && forced_speed_o == 2'h2)
    else $error("init");
  a_duplex_bit: assert property (
    w |=> full_duplex_o == $past(mgmt_wdata_i[8])) else $error("duplex");
  a_reneg_set: assert property (
    w && mgmt_wdata_i[9] |=> renegotiate_link_o) else $error("restart");
  a_reneg_clear: assert property (
    renegotiate_ack_i && renegotiate_link_o && !t |=> !renegotiate_link_o)
    else $error("ack");
  a_isolate_bit: assert property (
    w |=> isolate_o == $past(mgmt_wdata_i[10])) else $error("isolate");
  a_col_check: assert property (
    w |=> collision_signal_check_o == $past(mgmt_wdata_i[7])) else $error("collision test");
  a_neg_bit: assert property (
    w |=> link_negotiation_on_o == $past(mgmt_wdata_i[12])) else $error("negotiation");
  a_low_power: assert property (
    $past(mgmt_addr_i) == 5'h00 && !$past(rst_i) && !$past(rst_i, 2)
      |-> mgmt_rdata_o[11] == $past(low_power_state_i, 2))
    else $error("power-down bit");
  a_rsvd_read: assert property (
    $past(mgmt_addr_i) != 5'h00 |-> mgmt_rdata_o == 16'h0000) else $error("rsvd");
endmodule : bmc_checker

// >>> test/bmc_basic_mode_control_bench.sv
// Bench for the control register
`timescale 1ns/1ns
module bmc_basic_mode_control_bench;
  logic mclk_i = 1'h0, rst_i = 1'h1, mgmt_wr_i = 1'h0;
  logic low_power_state_i = 1'h0, renegotiate_ack_i = 1'h0;
  logic [4:0] mgmt_addr_i = 5'h00;
  logic [15:0] mgmt_wdata_i = 16'h0000, mgmt_rdata_o;
  logic std_regs_reset_o, loopback_o, link_negotiation_on_o, isolate_o;
  logic renegotiate_link_o, full_duplex_o, collision_signal_check_o;
  logic [1:0] forced_speed_o;
  int bad_count = 0, tests_run = 0;
  bmc_basic_mode_control dut (.*);
  always #50 mclk_i = ~mclk_i;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i) #5;
    mgmt_addr_i = a;
    mgmt_wdata_i = d;
    mgmt_wr_i = 1'h1;
    @(posedge mclk_i) #5;
    mgmt_wr_i = 1'h0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk_i) #5;
    mgmt_addr_i = a;
    @(posedge mclk_i) #5;
    tests_run++;
    if (mgmt_rdata_o !== e) begin
      bad_count++;
      $display("mismatch at %0t: read %h", $time, mgmt_rdata_o);
    end
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(posedge mclk_i);
    #5 rst_i = 1'h0;
    rd(5'h00, 16'h1140);
    rd(5'h01, 16'h0000);
    wr(5'h00, 16'h77FF);
    rd(5'h00, 16'h77C0);
    // Link logic acknowledges the restart
    renegotiate_ack_i = 1'h1;
    rd(5'h00, 16'h75C0);
    low_power_state_i = 1'h1;
    wr(5'h00, 16'h0000);
    rd(5'h00, 16'h0840);
    wr(5'h00, 16'hC000);
    // Bounded wait of 12 cycles; a stuck reset fails the std_regs_reset_o check that follows
    for (int i = 0; i < 12 && std_regs_reset_o !== 1'h0; i++) @(posedge mclk_i) #5;
    tests_run++;
    if (std_regs_reset_o !== 1'h0) begin
      bad_count++;
      $display("mismatch at %0t: soft reset did not clear", $time);
    end
    rd(5'h00, 16'h1940);
    end_sim();
  end
endmodule : bmc_basic_mode_control_bench
bind bmc_basic_mode_control bmc_checker u_chk (.*);
